// ===== fpepc_device.sv
`timescale 1ns/1ps
// Summary of operation
// - Flash accesses stall until operation completes.
// - Sixteen protect blocks; erase per page, write per word.
// - Nonexistent region access returns bus error.
// - Programming needs write-enable bit set.
// - Only full word writes; narrower writes refused.
// - Programming clears bits only; software masks data.
// - Protected write or page erase refused with fault.
// - Software checks status idle before writing.
// - Keyed mass erase code erases user flash.
// - Keyed page erase, then command done flag.
// - Fixed write and erase durations.
// - Verify and signature take fixed duration.
// - Key valid only after low then high half.
// - Key cleared when written command completes.
// - Any other key write drops the key.
// - Keyed setup write; debug bit zero disables.
// - Debug disabled during boot, enabled after.
// - Protection word loaded from array after reset.
// - Zero bit protects; a non-blank loaded copy is kept till reset.
// - Blank protection allows direct register writes.
// - Top protection bit guards protection block.
// - Unkeyed write to protection word faults.
// - Signature command code starts signature run.
// - Result keeps first error; status read clears.
module fpepc_device #(
  parameter logic [20:0] ERASE_CYC = fpepc_pkg::CYC_ERASE,
  parameter logic [20:0] SIGN_CYC  = fpepc_pkg::CYC_SIGN
) (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  fpepc_if.dev_mp          bus,
  output logic [18:0]      arr_addr_o,
  output logic [31:0]      arr_wdata_o,
  output logic             arr_write_o,
  output logic             arr_page_erase_o,
  output logic             arr_mass_erase_o,
  input  wire logic [31:0] arr_rdata_i,
  output logic             debug_en_o,
  output logic             busy_o
);

  typedef enum logic [6:0] {
    S_BOOT_RD  = 7'h01,
    S_BOOT_CAP = 7'h02,
    S_IDLE     = 7'h04,
    S_RD       = 7'h08,
    S_WRITE    = 7'h10,
    S_ERASE    = 7'h20,
    S_SIGN     = 7'h40
  } fpepc_dst_t;

  typedef struct packed {
    fpepc_dst_t  st;
    logic [1:0]  key;
    logic        we;
    logic        dbg;
    logic [31:0] prot;
    logic        prot_blank;
    logic [3:0]  cmd;
    logic [15:0] adr_l;
    logic [15:0] adr_h;
    logic        cmd_busy;
    logic        wr_busy;
    logic        cmd_done;
    logic        wr_done;
    logic [1:0]  res;
    logic [20:0] cnt;
    logic        rdy;
    logic        err;
    logic        fault;
    logic [31:0] rdata;
    logic [18:0] aaddr;
    logic [31:0] awdata;
    logic        awrite;
    logic        aperase;
    logic        amerase;
  } fpepc_dstate_t;

  localparam fpepc_dstate_t RST = '{
    st: S_BOOT_RD, key: fpepc_pkg::KEY_NONE, prot: fpepc_pkg::ALL_ONES,
    cmd: fpepc_pkg::CMD_IDLE, res: fpepc_pkg::RES_OK, default: '0
  };

  fpepc_dstate_t s_r;
  fpepc_dstate_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // A block is guarded when either of its two protection bits is zero.
  function automatic logic blk_prot(input logic [31:0] p, input logic [18:0] a);
    logic [3:0] b;
    b = a[fpepc_pkg::BLOCK_LSB +: 4];
    blk_prot = !(p[{b, 1'b0}] & p[{b, 1'b1}]);
  endfunction

  // Keeps the first error until a status read clears it.
  function automatic logic [1:0] first_err(input logic [1:0] cur, input logic [1:0] e);
    first_err = (cur == fpepc_pkg::RES_OK) ? e : cur;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Register accesses are served in every state but the two boot states; flash work only when idle.
  always_comb begin
    logic [18:0] pg;
    pg = {s_r.adr_h[2:0], s_r.adr_l[15:fpepc_pkg::PAGE_LSB], 11'h000};
    s_nxt = s_r;
    s_nxt.rdy = 1'b0;
    s_nxt.err = 1'b0;
    s_nxt.fault = 1'b0;
    s_nxt.awrite = 1'b0;
    s_nxt.aperase = 1'b0;
    s_nxt.amerase = 1'b0;
    // Register space: answered one cycle after the request is taken.
    if (bus.req && bus.reg_sel && !s_r.rdy && s_r.st != S_BOOT_RD
        && s_r.st != S_BOOT_CAP) begin
      s_nxt.rdy = 1'b1;
      s_nxt.rdata = 32'h00000000;
      if (bus.addr[7:0] == fpepc_pkg::R_STA) begin
        if (!bus.wr) begin
          s_nxt.rdata = {26'h0000000, s_r.res, s_r.wr_done, s_r.cmd_done,
                         s_r.wr_busy, s_r.cmd_busy};
          s_nxt.res = fpepc_pkg::RES_OK;
          s_nxt.cmd_done = 1'b0;
          s_nxt.wr_done = 1'b0;
        end
      end else if (bus.addr[7:0] == fpepc_pkg::R_CON0) begin
        if (bus.wr) begin
          s_nxt.we = bus.wdata[fpepc_pkg::CON0_WE_BIT];
        end
        s_nxt.rdata[fpepc_pkg::CON0_WE_BIT] = s_r.we;
      end else if (bus.addr[7:0] == fpepc_pkg::R_CMD) begin
        if (bus.wr && s_r.st == S_IDLE) begin
          s_nxt.cmd = bus.wdata[3:0];
          s_nxt.cmd_busy = 1'b1;
          if (bus.wdata[3:0] == fpepc_pkg::CMD_MASS_ER && s_r.key == fpepc_pkg::KEY_VALID) begin
            s_nxt.amerase = 1'b1;
            s_nxt.cnt = ERASE_CYC - fpepc_pkg::CNT_ONE;
            s_nxt.st = S_ERASE;
          end else if (bus.wdata[3:0] == fpepc_pkg::CMD_PAGE_ER
                       && s_r.key == fpepc_pkg::KEY_VALID && pg < fpepc_pkg::INFO_BASE
                       && !blk_prot(s_r.prot, pg)) begin
            s_nxt.aaddr = pg;
            s_nxt.aperase = 1'b1;
            s_nxt.cnt = ERASE_CYC - fpepc_pkg::CNT_ONE;
            s_nxt.st = S_ERASE;
          end else if (bus.wdata[3:0] == fpepc_pkg::CMD_SIGN
                       || bus.wdata[3:0] == fpepc_pkg::CMD_VERIFY) begin
            s_nxt.cnt = SIGN_CYC - fpepc_pkg::CNT_ONE;
            s_nxt.st = S_SIGN;
          end else begin
            // Refused command: done at once, result records the refusal.
            s_nxt.cmd_busy = 1'b0;
            s_nxt.cmd_done = 1'b1;
            s_nxt.cmd = fpepc_pkg::CMD_IDLE;
            s_nxt.key = fpepc_pkg::KEY_NONE;
            s_nxt.res = first_err(s_r.res, fpepc_pkg::RES_DENIED);
            s_nxt.fault = (bus.wdata[3:0] == fpepc_pkg::CMD_PAGE_ER)
                          && blk_prot(s_r.prot, pg);
            s_nxt.err = s_nxt.fault;
          end
        end
        s_nxt.rdata[3:0] = s_r.cmd;
      end else if (bus.addr[7:0] == fpepc_pkg::R_ADR0L) begin
        if (bus.wr) s_nxt.adr_l = bus.wdata[15:0];
        s_nxt.rdata[15:0] = s_r.adr_l;
      end else if (bus.addr[7:0] == fpepc_pkg::R_ADR0H) begin
        if (bus.wr) s_nxt.adr_h = bus.wdata[15:0];
        s_nxt.rdata[15:0] = s_r.adr_h;
      end else if (bus.addr[7:0] == fpepc_pkg::R_KEY) begin
        if (bus.wr) begin
          if (bus.wdata[15:0] == fpepc_pkg::KEY_LO) begin
            s_nxt.key = fpepc_pkg::KEY_HALF;
          end else if (s_r.key == fpepc_pkg::KEY_HALF && bus.wdata[15:0] == fpepc_pkg::KEY_HI) begin
            s_nxt.key = fpepc_pkg::KEY_VALID;
          end else begin
            s_nxt.key = fpepc_pkg::KEY_NONE;
          end
        end
      end else if (bus.addr[7:0] == fpepc_pkg::R_PROL) begin
        if (bus.wr && s_r.prot_blank) s_nxt.prot[15:0] = bus.wdata[15:0];
        s_nxt.rdata[15:0] = s_r.prot[15:0];
      end else if (bus.addr[7:0] == fpepc_pkg::R_PROH) begin
        if (bus.wr && s_r.prot_blank) s_nxt.prot[31:16] = bus.wdata[15:0];
        s_nxt.rdata[15:0] = s_r.prot[31:16];
      end else if (bus.addr[7:0] == fpepc_pkg::R_CON1) begin
        if (bus.wr && s_r.key == fpepc_pkg::KEY_VALID) begin
          s_nxt.dbg = bus.wdata[fpepc_pkg::CON1_DBG_BIT];
        end
        s_nxt.rdata[fpepc_pkg::CON1_DBG_BIT] = s_r.dbg;
      end else begin
        s_nxt.err = 1'b1;
      end
    end
    // Flash side sequencer; its completions are applied after any status
    // read above, so a completion in the same cycle as a read is not lost.
    case (s_r.st)
      S_BOOT_RD: begin
        s_nxt.aaddr = fpepc_pkg::PROT_ADDR;
        s_nxt.st = S_BOOT_CAP;
      end
      S_BOOT_CAP: begin
        s_nxt.prot = arr_rdata_i;
        s_nxt.prot_blank = (arr_rdata_i == fpepc_pkg::ALL_ONES);
        s_nxt.dbg = 1'b1;
        s_nxt.st = S_IDLE;
      end
      S_IDLE: begin
        if (bus.req && !bus.reg_sel && !s_r.rdy) begin
          if (bus.addr >= fpepc_pkg::INFO_TOP) begin
            s_nxt.rdy = 1'b1;
            s_nxt.err = 1'b1;
          end else if (!bus.wr) begin
            s_nxt.aaddr = bus.addr;
            s_nxt.st = S_RD;
          end else if (bus.size != fpepc_pkg::SZ_WORD || bus.addr >= fpepc_pkg::INFO_BASE
                       || !s_r.we) begin
            s_nxt.rdy = 1'b1;
            s_nxt.err = 1'b1;
            s_nxt.res = first_err(s_r.res, fpepc_pkg::RES_DENIED);
          end else if ((bus.addr[18:2] == fpepc_pkg::PROT_ADDR[18:2]
                        && s_r.key != fpepc_pkg::KEY_VALID)
                       || blk_prot(s_r.prot, bus.addr)) begin
            s_nxt.rdy = 1'b1;
            s_nxt.err = 1'b1;
            s_nxt.fault = 1'b1;
            s_nxt.res = first_err(s_r.res, fpepc_pkg::RES_DENIED);
          end else begin
            s_nxt.aaddr = bus.addr;
            s_nxt.awdata = bus.wdata;
            s_nxt.awrite = 1'b1;
            s_nxt.wr_busy = 1'b1;
            s_nxt.cnt = fpepc_pkg::CYC_WRITE - fpepc_pkg::CNT_ONE;
            s_nxt.st = S_WRITE;
          end
        end
      end
      S_RD: begin
        s_nxt.rdata = arr_rdata_i;
        s_nxt.rdy = 1'b1;
        s_nxt.st = S_IDLE;
      end
      S_WRITE: begin
        if (s_r.cnt == 21'h000000) begin
          s_nxt.wr_busy = 1'b0;
          s_nxt.wr_done = 1'b1;
          s_nxt.rdy = 1'b1;
          s_nxt.st = S_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - fpepc_pkg::CNT_ONE;
        end
      end
      S_ERASE, S_SIGN: begin
        if (s_r.cnt == 21'h000000) begin
          s_nxt.cmd_busy = 1'b0;
          s_nxt.cmd_done = 1'b1;
          s_nxt.cmd = fpepc_pkg::CMD_IDLE;
          s_nxt.key = fpepc_pkg::KEY_NONE;
          s_nxt.st = S_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - fpepc_pkg::CNT_ONE;
        end
      end
      default: begin
        s_nxt.st = S_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s_r <= RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all taken from the state register.

  assign bus.rdy          = s_r.rdy;
  assign bus.err          = s_r.err;
  assign bus.fault        = s_r.fault;
  assign bus.rdata        = s_r.rdata;
  assign arr_addr_o       = s_r.aaddr;
  assign arr_wdata_o      = s_r.awdata;
  assign arr_write_o      = s_r.awrite;
  assign arr_page_erase_o = s_r.aperase;
  assign arr_mass_erase_o = s_r.amerase;
  assign debug_en_o       = s_r.dbg;
  assign busy_o           = s_r.cmd_busy | s_r.wr_busy;

endmodule

// ===== fpepc_pkg.sv
package fpepc_pkg;

  // Flash address space, byte addressed.
  localparam int          FA_W        = 19;
  localparam logic [18:0] INFO_BASE   = 19'h40000;
  localparam logic [18:0] INFO_TOP    = 19'h40800;
  localparam logic [18:0] PROT_ADDR   = 19'h3fff8;
  localparam int          BLOCK_LSB   = 14;
  localparam int          PAGE_LSB    = 11;

  // Register offsets.
  localparam logic [7:0]  R_STA       = 8'h00;
  localparam logic [7:0]  R_CON0      = 8'h04;
  localparam logic [7:0]  R_CMD       = 8'h08;
  localparam logic [7:0]  R_ADR0L     = 8'h10;
  localparam logic [7:0]  R_ADR0H     = 8'h14;
  localparam logic [7:0]  R_KEY       = 8'h20;
  localparam logic [7:0]  R_PROL      = 8'h28;
  localparam logic [7:0]  R_PROH      = 8'h2c;
  localparam logic [7:0]  R_CON1      = 8'h38;

  // Field positions.
  localparam int          CON0_WE_BIT = 2;
  localparam int          CON1_DBG_BIT = 0;

  // Unlock key halves and key progress codes.
  localparam logic [15:0] KEY_LO      = 16'hf456;
  localparam logic [15:0] KEY_HI      = 16'hf123;
  localparam logic [1:0]  KEY_NONE    = 2'h0;
  localparam logic [1:0]  KEY_HALF    = 2'h1;
  localparam logic [1:0]  KEY_VALID   = 2'h2;

  // Command codes.
  localparam logic [3:0]  CMD_IDLE    = 4'h0;
  localparam logic [3:0]  CMD_PAGE_ER = 4'h1;
  localparam logic [3:0]  CMD_SIGN    = 4'h2;
  localparam logic [3:0]  CMD_MASS_ER = 4'h3;
  localparam logic [3:0]  CMD_VERIFY  = 4'h4;

  // Command result codes.
  localparam logic [1:0]  RES_OK      = 2'h0;
  localparam logic [1:0]  RES_DENIED  = 2'h1;
  localparam logic [1:0]  RES_FAIL    = 2'h2;

  // Access sizes.
  localparam logic [1:0]  SZ_BYTE     = 2'h0;
  localparam logic [1:0]  SZ_HALF     = 2'h1;
  localparam logic [1:0]  SZ_WORD     = 2'h2;

  // Avalon response codes.
  localparam logic [1:0]  AV_OKAY     = 2'h0;
  localparam logic [1:0]  AV_SLVERR   = 2'h2;

  localparam logic [31:0] ALL_ONES    = 32'hffffffff;

  // Operation times and their cycle counts at the system clock.
  localparam int          CLK_NS      = 20;
  localparam int          T_WRITE_NS  = 46000;
  localparam int          T_ERASE_NS  = 21000000;
  localparam int          T_SIGN_NS   = 2050000;
  localparam int          CNT_W       = 21;
  localparam logic [20:0] CYC_WRITE   = 21'((T_WRITE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [20:0] CYC_ERASE   = 21'((T_ERASE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [20:0] CYC_SIGN    = 21'((T_SIGN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [20:0] CNT_ONE     = 21'h000001;

endpackage

// ===== fpepc_if.sv
`timescale 1ns/1ps
// Request and answer link between the processor side and the flash controller.
interface fpepc_if;
  logic        req;
  logic        wr;
  logic        reg_sel;
  logic [1:0]  size;
  logic [18:0] addr;
  logic [31:0] wdata;
  logic        rdy;
  logic        err;
  logic        fault;
  logic [31:0] rdata;

  modport dev_mp (
    input  req, wr, reg_sel, size, addr, wdata,
    output rdy, err, fault, rdata
  );

  modport host_mp (
    output req, wr, reg_sel, size, addr, wdata,
    input  rdy, err, fault, rdata
  );
endinterface

// ===== fpepc_host.sv
`timescale 1ns/1ps
// Processor-side end: turns Avalon-MM accesses into link requests.
module fpepc_host (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  fpepc_if.host_mp         bus,
  input  wire logic [19:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic [1:0]       avs_response_o,
  output logic             hard_fault_o
);

  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_WAIT = 3'h2,
    H_DONE = 3'h4
  } fpepc_hst_t;

  typedef struct packed {
    fpepc_hst_t  st;
    logic        req;
    logic        wr;
    logic        reg_sel;
    logic [1:0]  size;
    logic [18:0] addr;
    logic [31:0] wdata;
    logic        wait_n_ok;
    logic [31:0] rdata;
    logic [1:0]  resp;
    logic        fault;
  } fpepc_hstate_t;

  localparam fpepc_hstate_t RST = '{st: H_IDLE, wait_n_ok: 1'b1, default: '0};

  fpepc_hstate_t h_r;
  fpepc_hstate_t h_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Maps byte enables to an access size; the device refuses narrow writes.
  function automatic logic [1:0] be_size(input logic [3:0] be);
    if (be == 4'hf) begin
      be_size = fpepc_pkg::SZ_WORD;
    end else if (be == 4'h3 || be == 4'hc) begin
      be_size = fpepc_pkg::SZ_HALF;
    end else begin
      be_size = fpepc_pkg::SZ_BYTE;
    end
  endfunction

  // One link request per Avalon access; waitrequest drops for one cycle.
  always_comb begin
    h_nxt = h_r;
    h_nxt.fault = 1'b0;
    case (h_r.st)
      H_IDLE: begin
        h_nxt.wait_n_ok = 1'b1;
        if (avs_read_i || avs_write_i) begin
          h_nxt.req = 1'b1;
          h_nxt.wr = avs_write_i;
          h_nxt.reg_sel = avs_address_i[19];
          h_nxt.addr = avs_address_i[18:0];
          h_nxt.wdata = avs_writedata_i;
          h_nxt.size = be_size(avs_byteenable_i);
          h_nxt.st = H_WAIT;
        end
      end
      H_WAIT: begin
        if (bus.rdy) begin
          h_nxt.req = 1'b0;
          h_nxt.wait_n_ok = 1'b0;
          h_nxt.rdata = bus.rdata;
          h_nxt.resp = bus.err ? fpepc_pkg::AV_SLVERR : fpepc_pkg::AV_OKAY;
          h_nxt.fault = bus.fault;
          h_nxt.st = H_DONE;
        end
      end
      H_DONE: begin
        h_nxt.wait_n_ok = 1'b1;
        h_nxt.resp = fpepc_pkg::AV_OKAY;
        h_nxt.st = H_IDLE;
      end
      default: begin
        h_nxt.st = H_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      h_r <= RST;
    end else begin
      h_r <= h_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all taken from the state register.

  assign bus.req           = h_r.req;
  assign bus.wr            = h_r.wr;
  assign bus.reg_sel       = h_r.reg_sel;
  assign bus.size          = h_r.size;
  assign bus.addr          = h_r.addr;
  assign bus.wdata         = h_r.wdata;
  assign avs_readdata_o    = h_r.rdata;
  assign avs_waitrequest_o = h_r.wait_n_ok;
  assign avs_response_o    = h_r.resp;
  assign hard_fault_o      = h_r.fault;

endmodule

// ===== fpepc_props.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Watches the link between the host end and the device end.
module fpepc_props (
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic        req,
  input wire logic        wr,
  input wire logic        reg_sel,
  input wire logic [1:0]  size,
  input wire logic [18:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        rdy,
  input wire logic        err,
  input wire logic        fault,
  input wire logic [31:0] rdata
);
  localparam int WR_CYC = 2300;
  typedef struct packed {
    logic        half;
    logic        ok;
    logic [12:0] cnt;
  } fpepc_chk_t;
  fpepc_chk_t st_r;
  fpepc_chk_t st_nxt;
  logic       reg_wr;

  // Tracks the key and how long a request waited.
  assign reg_wr = rdy && req && wr && reg_sel;
  always_comb begin
    st_nxt = st_r;
    st_nxt.cnt = req ? st_r.cnt + {12'h000, ~&st_r.cnt} : 13'h0000;
    if (reg_wr && addr[7:0] == fpepc_pkg::R_KEY) begin
      st_nxt.ok = st_r.half && wdata[15:0] == fpepc_pkg::KEY_HI;
      st_nxt.half = wdata[15:0] == fpepc_pkg::KEY_LO;
    end
    if (reg_wr && addr[7:0] == fpepc_pkg::R_CMD) begin
      st_nxt.ok = 1'b0;
      st_nxt.half = 1'b0;
    end
  end

  // Registers the helper state.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  ////////////////////////////////////////////////////////////////////////////////
  // Answers are pulses closing a pending request.
  rdy_pulse_a: assert property (rdy |=> !rdy) else $error("answer too long");
  answer_req_a: assert property (rdy |-> req) else $error("stray answer");
  rdata_hold_a: assert property (!rdy ##1 !rdy |-> $stable(rdata))
    else $error("rdata moved");
  err_rdy_a: assert property (err |-> rdy) else $error("error without answer");
  missing_err_a: assert property (rdy && !reg_sel && addr >= fpepc_pkg::INFO_TOP |-> err)
    else $error("missing region ok");
  narrow_err_a: assert property (rdy && wr && !reg_sel && size != fpepc_pkg::SZ_WORD |-> err)
    else $error("narrow write accepted");
  fault_err_a: assert property (fault |-> err && rdy) else $error("fault without error");
  prot_key_a: assert property (rdy && wr && !reg_sel && addr == fpepc_pkg::PROT_ADDR
    && !st_r.ok |-> err && fault) else $error("unkeyed write ok");
  reg_answer_a: assert property ($rose(req) && reg_sel |-> ##[1:3] rdy)
    else $error("no reg answer");
  write_time_a: assert property (rdy && wr && !reg_sel && !err |-> st_r.cnt >= 13'(WR_CYC))
    else $error("write too early");
endmodule

// ===== fpepc_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("CHECK FAILED at %0t: %s", $time, msg); end end
////////////////////////////////////////////////////////////////////////////////
module tb;
  typedef struct {
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0]  r;
    logic        rc;
    logic        f;
  } fpepc_note_t;
  logic        clock_i;
  logic        reset_i;
  logic [19:0] avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [1:0]  avs_response_o;
  logic        hard_fault_o;
  logic [18:0] arr_addr;
  logic [31:0] arr_wdata;
  logic        arr_write;
  logic        arr_pe;
  logic        arr_me;
  logic        debug_en;
  logic        busy;
  logic [31:0] mem [0:66047];
  logic [31:0] d1;
  logic [31:0] d2;
  logic [3:0]  codes [4];
  int          err_total;
  int          check_count;
  int          pe_cnt;
  int          me_cnt;
  fpepc_note_t notes [$];

  fpepc_if u_fpepc_if ();
  fpepc_host u_fpepc_host (.clock_i(clock_i), .reset_i(reset_i), .bus(u_fpepc_if),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .avs_response_o(avs_response_o), .hard_fault_o(hard_fault_o));
  fpepc_device #(.ERASE_CYC(21'h000014), .SIGN_CYC(21'h00000a)) u_fpepc_device (
    .clock_i(clock_i), .reset_i(reset_i), .bus(u_fpepc_if), .arr_addr_o(arr_addr),
    .arr_wdata_o(arr_wdata), .arr_write_o(arr_write), .arr_page_erase_o(arr_pe),
    .arr_mass_erase_o(arr_me), .arr_rdata_i(mem[arr_addr[18:2]]), .debug_en_o(debug_en),
    .busy_o(busy));
  fpepc_props u_fpepc_props (.clock_i(clock_i), .reset_i(reset_i), .req(u_fpepc_if.req),
    .wr(u_fpepc_if.wr), .reg_sel(u_fpepc_if.reg_sel), .size(u_fpepc_if.size),
    .addr(u_fpepc_if.addr), .wdata(u_fpepc_if.wdata), .rdy(u_fpepc_if.rdy),
    .err(u_fpepc_if.err), .fault(u_fpepc_if.fault), .rdata(u_fpepc_if.rdata));

  // Clock at 50 MHz.
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // Flash array: writes clear bits, erases set ones.
  always @(posedge clock_i) begin
    if (arr_write) mem[arr_addr[18:2]] <= mem[arr_addr[18:2]] & arr_wdata;
    if (arr_pe) begin
      pe_cnt++;
      for (int i = 0; i < 512; i++) mem[{arr_addr[18:11], 9'(i)}] <= '1;
    end
    if (arr_me) begin
      me_cnt++;
      for (int i = 0; i < 65536; i++) mem[i] <= '1;
    end
  end

  // Compares each answer with the oldest note.
  always @(posedge clock_i) begin
    if (avs_waitrequest_o === 1'b0) begin
      fpepc_note_t n;
      n = notes.pop_front();
      `CHK(avs_readdata_o & n.m, n.d & n.m, "read data")
      if (n.rc) `CHK(avs_response_o, n.r, "response")
      `CHK(hard_fault_o, n.f, "hard fault")
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One Avalon access; its answer is noted first.
  task automatic av(input logic w, input logic [19:0] a, input logic [31:0] d,
                    input logic [3:0] be, input logic [31:0] ed, input logic [31:0] em,
                    input logic rc, input logic [1:0] er, input logic ef);
    int n;
    notes.push_back('{ed, em, er, rc, ef});
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= w;
    avs_read_i <= !w;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 5000);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 5000) begin
      err_total++;
      $display("CHECK FAILED at %0t: no answer", $time);
      print_verdict();
    end
  endtask

  task automatic wr_r(input logic [7:0] o, input logic [31:0] d, input logic rc);
    av(1'b1, {12'h800, o}, d, 4'hf, 32'h0, 32'h0, rc, fpepc_pkg::AV_OKAY, 1'b0);
  endtask
  task automatic rd_r(input logic [7:0] o, input logic [31:0] ed, input logic [31:0] em);
    av(1'b0, {12'h800, o}, 32'h0, 4'hf, ed, em, 1'b1, fpepc_pkg::AV_OKAY, 1'b0);
  endtask
  task automatic fl(input logic w, input logic [18:0] a, input logic [31:0] d,
                    input logic [3:0] be, input logic [31:0] ed, input logic [1:0] er,
                    input logic ef);
    av(w, {1'b0, a}, d, be, ed, w ? 32'h0 : 32'hffffffff, 1'b1, er, ef);
  endtask
  task automatic key();
    wr_r(fpepc_pkg::R_KEY, {16'h0000, fpepc_pkg::KEY_LO}, 1'b1);
    wr_r(fpepc_pkg::R_KEY, {16'h0000, fpepc_pkg::KEY_HI}, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    reset_i = 1'b1;
    {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i, avs_byteenable_i} = '0;
    for (int i = 0; i < 66048; i++) mem[i] = '1;
    codes = '{fpepc_pkg::CMD_SIGN, fpepc_pkg::CMD_VERIFY, fpepc_pkg::CMD_PAGE_ER,
              fpepc_pkg::CMD_MASS_ER};
    void'($urandom(14774));
    repeat (4) @(posedge clock_i);
    `CHK(debug_en, 1'b0, "boot debug")
    repeat (12) @(posedge clock_i);
    reset_i <= 1'b0;
    rd_r(fpepc_pkg::R_STA, 32'h0, 32'h3f);
    rd_r(fpepc_pkg::R_CON1, 32'h1, 32'h1);
    rd_r(fpepc_pkg::R_PROL, 32'hffff, 32'hffff);
    $display("test boot finished");
    wr_r(fpepc_pkg::R_CON1, 32'h0, 1'b0);
    rd_r(fpepc_pkg::R_CON1, 32'h1, 32'h1);
    key();
    wr_r(fpepc_pkg::R_CON1, 32'h0, 1'b1);
    rd_r(fpepc_pkg::R_CON1, 32'h0, 32'h1);
    wr_r(fpepc_pkg::R_KEY, 32'h0, 1'b1);
    wr_r(fpepc_pkg::R_CON1, 32'h1, 1'b0);
    rd_r(fpepc_pkg::R_CON1, 32'h0, 32'h1);
    `CHK(debug_en, 1'b0, "debug")
    $display("test setup finished");
    for (int i = 0; i < 4; i++)
      fl(i[0], 19'h40800 + 19'($urandom_range(0, 32'h377ff)), $urandom, 4'hf, 32'h0,
         fpepc_pkg::AV_SLVERR, 1'b0);
    $display("test missing region finished");
    d1 = $urandom;
    d2 = $urandom;
    fl(1'b1, 19'h04000, d1, 4'hf, 32'h0, fpepc_pkg::AV_SLVERR, 1'b0);
    wr_r(fpepc_pkg::R_CON0, 32'h4, 1'b1);
    fl(1'b1, 19'h04000, d1, 4'h1, 32'h0, fpepc_pkg::AV_SLVERR, 1'b0);
    fl(1'b1, 19'h04000, d1, 4'h3, 32'h0, fpepc_pkg::AV_SLVERR, 1'b0);
    rd_r(fpepc_pkg::R_STA, 32'h10, 32'h30);
    fl(1'b1, 19'h04000, d1, 4'hf, 32'h0, fpepc_pkg::AV_OKAY, 1'b0);
    fl(1'b1, 19'h04000, d2, 4'hf, 32'h0, fpepc_pkg::AV_OKAY, 1'b0);
    fl(1'b0, 19'h04000, 32'h0, 4'hf, d1 & d2, fpepc_pkg::AV_OKAY, 1'b0);
    rd_r(fpepc_pkg::R_STA, 32'h08, 32'h3f);
    $display("test write finished");
    wr_r(fpepc_pkg::R_PROL, 32'hfffe, 1'b1);
    rd_r(fpepc_pkg::R_PROL, 32'hfffe, 32'hffff);
    fl(1'b1, 19'h00100, d1, 4'hf, 32'h0, fpepc_pkg::AV_SLVERR, 1'b1);
    fl(1'b1, fpepc_pkg::PROT_ADDR, d1, 4'hf, 32'h0, fpepc_pkg::AV_SLVERR, 1'b1);
    rd_r(fpepc_pkg::R_STA, 32'h10, 32'h30);
    rd_r(fpepc_pkg::R_STA, 32'h00, 32'h30);
    wr_r(fpepc_pkg::R_PROH, 32'h7fff, 1'b1);
    key();
    av(1'b1, 20'h80008, 32'h1, 4'hf, 32'h0, 32'h0, 1'b1, fpepc_pkg::AV_SLVERR, 1'b1);
    $display("test protection finished");
    wr_r(fpepc_pkg::R_ADR0L, 32'h4000, 1'b1);
    wr_r(fpepc_pkg::R_ADR0H, 32'h0, 1'b1);
    wr_r(fpepc_pkg::R_CMD, 32'h1, 1'b1);
    rd_r(fpepc_pkg::R_STA, 32'h14, 32'h34);
    foreach (codes[i]) begin
      key();
      wr_r(fpepc_pkg::R_CMD, {28'h0, codes[i]}, 1'b1);
      `CHK(busy, 1'b1, "busy")
      av(1'b0, 20'h04000, 32'h0, 4'hf, 32'hffffffff, (i > 1) ? 32'hffffffff : 32'h0, 1'b1,
         fpepc_pkg::AV_OKAY, 1'b0);
      rd_r(fpepc_pkg::R_STA, 32'h04, 32'h37);
    end
    `CHK(pe_cnt, 1, "page erases")
    `CHK(me_cnt, 1, "mass erases")
    wr_r(fpepc_pkg::R_CMD, 32'h3, 1'b1);
    rd_r(fpepc_pkg::R_STA, 32'h14, 32'h34);
    wr_r(fpepc_pkg::R_KEY, {16'h0000, fpepc_pkg::KEY_HI}, 1'b1);
    wr_r(fpepc_pkg::R_KEY, {16'h0000, fpepc_pkg::KEY_LO}, 1'b1);
    wr_r(fpepc_pkg::R_CMD, 32'h3, 1'b1);
    rd_r(fpepc_pkg::R_STA, 32'h14, 32'h34);
    `CHK(me_cnt, 1, "wrong key")
    rd_r(fpepc_pkg::R_PROL, 32'hfffe, 32'hffff);
    $display("test commands finished");
    print_verdict();
  end
endmodule
